// File: rtl/fcr_flash_regs.sv
// module: flash controller mode, command and status registers
// ==========================================================
// Operation
// - ready raises interrupt when its enable set
// - lock and program errors each gated separately
// - page write erases first unless skip bit
// - wait states give read 1-4, write 2-4
// - microsecond count sets operation timing
// - command ignored unless key byte matches
// - command zero is silent no operation
// - write page programs named page
// - set lock locks region of page
// - write page then lock its region
// - clear lock unlocks region of page
// - erase all cancelled when any region locked
// - set or clear indexed user nvm bit
// - set security bit, page number ignored
// - reserved codes flag program error only
// - any page in region selects region
// - ready low while busy, high when idle
// - lock error set on locked write, read clears
// - program error on bad key or code
// - status shows security and user nvm bits
// - status top half shows region locks
// - valid command starts at once, drops ready
// - refused erase all flags lock error
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module fcr_flash_regs
  import fcr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire fcr_pkg::fcr_bus_t bus,
  output logic [31:0]            rdata,
  output logic                   irq,
  output fcr_pkg::fcr_array_t    array_op,
  output logic [2:0]             read_cycles,
  output logic [2:0]             write_cycles
);
  import fcr_pkg::*;

  // ==========================================================
  // sequencer states
  // one timed phase per busy state; the timer sets its length
  typedef enum logic [2:0] {
    FCR_IDLE,
    FCR_ERASE,
    FCR_PROG,
    FCR_BIT,
    FCR_ALL
  } fcr_state_t;

  // all state of the block
  // one struct keeps the whole register slice in one process,
  // so a freeze by clk_en can never split the state
  typedef struct packed {
    logic [31:0]      mode;     // flash_mode contents
    fcr_state_t       fsm;      // sequencer state
    fcr_op_t          op;       // command in progress
    logic [9:0]       page;     // page_number in progress
    logic             ready;    // ready_flag
    logic             lck_err;  // lock_error_flag
    logic             prg_err;  // program_error_flag
    logic             secure;   // security bit
    logic [1:0]       nvm;      // user_nvm_status
    logic [15:0]      locks;    // region_lock_status
    logic [31:0]      rdata;    // read data, one cycle late
    logic [2:0]       rd_cyc;   // read cycles from wait states
    logic [2:0]       wr_cyc;   // write cycles from wait states
  } fcr_regs_t;

  fcr_regs_t st_ff;  // registered state
  fcr_regs_t nxt_st; // next state

  // timer handshake
  // start is a one-cycle pulse; done pulses when a phase ends
  logic        tmr_start; // launch a timed phase
  logic [15:0] tmr_len;   // phase length in microseconds
  logic        tmr_done;  // phase finished

  // decoded command fields
  // taken straight off the write data, only meaningful with bus.wr
  logic [7:0]       cmd_key;
  fcr_op_t          cmd_op;
  logic [9:0]       cmd_page;
  logic [3:0]       cmd_region;
  logic [3:0]       cur_region;
  logic [31:0]      status_word;

  assign cmd_key    = bus.wdata[FCR_CMD_KEY_LO +: 8];
  assign cmd_op     = fcr_op_t'(bus.wdata[3:0]);
  assign cmd_page   = bus.wdata[FCR_CMD_PAGE_LO +: FCR_PAGE_W];
  // low page bits do not matter for region selection
  assign cmd_region = cmd_page[FCR_REG_SH +: FCR_REGION_W];
  assign cur_region = st_ff.page[FCR_REG_SH +: FCR_REGION_W];

  // ==========================================================
  // status word as software sees it
  // unused bits read zero; the lock error clear lives in the
  // read path below, not here
  always_comb
  begin
    status_word                             = 32'h0000_0000;
    status_word[FCR_ST_READY]               = st_ff.ready;
    status_word[FCR_ST_LCK_ERR]             = st_ff.lck_err;
    status_word[FCR_ST_PRG_ERR]             = st_ff.prg_err;
    status_word[FCR_ST_SECURE]              = st_ff.secure;
    status_word[FCR_ST_NVM_LO +: FCR_NVM_N] = st_ff.nvm;
    status_word[FCR_ST_LOCK_LO +: 16]       = st_ff.locks;
  end

  // ==========================================================
  // next state: bus, command decode and sequencer
  // defaults hold every field, so the branches below only
  // name the fields that change
  always_comb
  begin
    nxt_st    = st_ff;
    tmr_start = 1'b0;
    tmr_len   = FCR_T_ONE_US;

    // wait state table, write saturates at four
    // recomputed every cycle, so a mode write shows one cycle later
    case (st_ff.mode[FCR_MODE_WS_LO +: 2])
      2'd0:
      begin
        nxt_st.rd_cyc = 3'd1;
        nxt_st.wr_cyc = 3'd2;
      end
      2'd1:
      begin
        nxt_st.rd_cyc = 3'd2;
        nxt_st.wr_cyc = 3'd3;
      end
      2'd2:
      begin
        nxt_st.rd_cyc = 3'd3;
        nxt_st.wr_cyc = 3'd4;
      end
      default:
      begin
        nxt_st.rd_cyc = 3'd4;
        nxt_st.wr_cyc = 3'd4;
      end
    endcase

    // read path; reading status clears lock error
    // read data live for one cycle only, then drop back to zero
    nxt_st.rdata = 32'h0000_0000;
    if (bus.rd)
    begin
      if (bus.addr == FCR_OFS_MODE)
        nxt_st.rdata = st_ff.mode;
      else if (bus.addr == FCR_OFS_STATUS)
      begin
        nxt_st.rdata   = status_word;
        nxt_st.lck_err = 1'b0;
      end
      else
        nxt_st.rdata = 32'h0000_0000; // unmapped reads zero
    end

    // mode register write
    // reserved bits are masked off and read back as zero
    if (bus.wr && (bus.addr == FCR_OFS_MODE))
      nxt_st.mode = bus.wdata & FCR_MODE_MASK;

    // sequencer progress; set wins over the read clear above
    case (st_ff.fsm)
      // page erase done: go straight on to programming
      FCR_ERASE:
        if (tmr_done)
        begin
          nxt_st.fsm = FCR_PROG;
          tmr_start  = 1'b1;
          tmr_len    = FCR_T_PROG_US;
        end
      // programming done: the lock variant adds a bit phase
      FCR_PROG:
        if (tmr_done)
        begin
          if (st_ff.op == FCR_OP_WR_LCK)
          begin
            nxt_st.fsm = FCR_BIT; // lock after programming
            tmr_start  = 1'b1;
            tmr_len    = FCR_T_BIT_US;
          end
          else
          begin
            nxt_st.fsm   = FCR_IDLE;
            nxt_st.ready = 1'b1;
          end
        end
      // bit phase done: apply the lock, nvm or security change
      FCR_BIT:
        if (tmr_done)
        begin
          case (st_ff.op)
            FCR_OP_LOCK, FCR_OP_WR_LCK:
              nxt_st.locks[cur_region] = 1'b1;
            FCR_OP_UNLOCK:
              nxt_st.locks[cur_region] = 1'b0;
            // an nvm index out of range runs but changes nothing
            FCR_OP_NVM_ON:
              if (st_ff.page < 10'(FCR_NVM_N))
                nxt_st.nvm[st_ff.page[0]] = 1'b1;
            FCR_OP_NVM_OF:
              if (st_ff.page < 10'(FCR_NVM_N))
                nxt_st.nvm[st_ff.page[0]] = 1'b0;
            FCR_OP_SECURE:
              nxt_st.secure = 1'b1;
            default:
              nxt_st.secure = st_ff.secure;
          endcase
          nxt_st.fsm   = FCR_IDLE;
          nxt_st.ready = 1'b1;
        end
      // whole array erase done
      FCR_ALL:
        if (tmr_done)
        begin
          nxt_st.fsm   = FCR_IDLE;
          nxt_st.ready = 1'b1;
        end
      // idle and unused encodings settle back to idle
      default:
        nxt_st.fsm = FCR_IDLE;
    endcase

    // command write, taken only while idle
    // writes while busy are dropped without a flag, so software
    // must poll ready before the next command
    if (bus.wr && (bus.addr == FCR_OFS_COMMAND) &&
        (st_ff.fsm == FCR_IDLE))
    begin
      if (cmd_key != FCR_KEY_VALUE)
        nxt_st.prg_err = 1'b1; // wrong key: nothing starts
      else
      begin
        nxt_st.op   = cmd_op;
        nxt_st.page = cmd_page;
        case (cmd_op)
          // zero code: accepted, nothing starts
          FCR_OP_NOP:
            nxt_st.op = FCR_OP_NOP; // no flag
          // a locked target region refuses the write
          FCR_OP_WRITE, FCR_OP_WR_LCK:
            if (st_ff.locks[cmd_region])
              nxt_st.lck_err = 1'b1;
            else
            begin
              nxt_st.ready = 1'b0;
              tmr_start    = 1'b1;
              if (st_ff.mode[FCR_MODE_SKIP_ER])
              begin
                nxt_st.fsm = FCR_PROG;
                tmr_len    = FCR_T_PROG_US;
              end
              else
              begin
                nxt_st.fsm = FCR_ERASE;
                tmr_len    = FCR_T_ERASE_US;
              end
            end
          // short single bit operations share one phase
          FCR_OP_LOCK, FCR_OP_UNLOCK, FCR_OP_NVM_ON,
          FCR_OP_NVM_OF, FCR_OP_SECURE:
          begin
            nxt_st.fsm   = FCR_BIT;
            nxt_st.ready = 1'b0;
            tmr_start    = 1'b1;
            tmr_len      = FCR_T_BIT_US;
          end
          // any locked region cancels the whole erase
          FCR_OP_ERASE:
            if (st_ff.locks != FCR_LOCK_RESET)
              nxt_st.lck_err = 1'b1; // refused, nothing erased
            else
            begin
              nxt_st.fsm   = FCR_ALL;
              nxt_st.ready = 1'b0;
              tmr_start    = 1'b1;
              tmr_len      = FCR_T_ALL_US;
            end
          // codes outside the table are reserved
          default:
            nxt_st.prg_err = 1'b1; // reserved code
        endcase
      end
    end
  end

  // ==========================================================
  // register all state; security, nvm and locks model the nvm
  // cells and start cleared since no array is attached here
  // a freeze keeps every field, the timer included
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_ff       <= '0;
      st_ff.mode  <= FCR_MODE_RESET;
      st_ff.fsm   <= FCR_IDLE;
      st_ff.op    <= FCR_OP_NOP;
      st_ff.ready <= 1'b1;
      st_ff.locks <= FCR_LOCK_RESET;
    end
    else if (clk_en)
      st_ff <= nxt_st;
  end

  // ==========================================================
  // operation timer, paced by the microsecond count
  // it shares clk_en, so phases stretch while the block is frozen
  fcr_us_timer u_timer
  (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .cycles_per_us (st_ff.mode[FCR_MODE_US_LO +: 8]),
    .start         (tmr_start),
    .length_us     (tmr_len),
    .done          (tmr_done)
  );

  // ==========================================================
  // outputs
  // phase flags decode the registered state, so they cannot glitch
  assign rdata        = st_ff.rdata;
  assign read_cycles  = st_ff.rd_cyc;
  assign write_cycles = st_ff.wr_cyc;
  assign array_op.erase = (st_ff.fsm == FCR_ERASE);
  assign array_op.prog  = (st_ff.fsm == FCR_PROG);
  assign array_op.all   = (st_ff.fsm == FCR_ALL);
  assign array_op.page  = st_ff.page;

  // interrupt: or of each flag with its own enable
  // level output; falls only when the flag or its enable falls
  assign irq = (st_ff.ready   & st_ff.mode[FCR_MODE_RDY_IE]) |
               (st_ff.lck_err & st_ff.mode[FCR_MODE_LCK_IE]) |
               (st_ff.prg_err & st_ff.mode[FCR_MODE_PRG_IE]);

endmodule

// File: rtl/fcr_pkg.sv
// package: register map, field layout and timing constants of the flash regs
package fcr_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] FCR_OFS_MODE    = 8'h60; // flash_mode
  localparam logic [7:0] FCR_OFS_COMMAND = 8'h64; // flash_command
  localparam logic [7:0] FCR_OFS_STATUS  = 8'h68; // flash_status
  localparam logic [7:0] FCR_OFS_RSVD    = 8'h6c; // reserved_slot

  // ==========================================================
  // flash_mode field positions
  localparam int FCR_MODE_RDY_IE  = 0;  // ready interrupt enable
  localparam int FCR_MODE_LCK_IE  = 2;  // lock error interrupt enable
  localparam int FCR_MODE_PRG_IE  = 3;  // program error interrupt enable
  localparam int FCR_MODE_SKIP_ER = 7;  // skip_erase_bit
  localparam int FCR_MODE_WS_LO   = 8;  // wait_state_count lsb
  localparam int FCR_MODE_US_LO   = 16; // microsecond_cycle_count lsb
  localparam logic [31:0] FCR_MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] FCR_MODE_MASK  = 32'h00ff_038d; // writable bits

  // ==========================================================
  // flash_command field positions and key
  localparam int FCR_CMD_PAGE_LO = 8;  // page_number lsb
  localparam int FCR_CMD_KEY_LO  = 24; // key byte lsb
  localparam logic [7:0] FCR_KEY_VALUE = 8'h5a;

  // ==========================================================
  // flash_status field positions
  localparam int FCR_ST_READY   = 0;
  localparam int FCR_ST_LCK_ERR = 2;
  localparam int FCR_ST_PRG_ERR = 3;
  localparam int FCR_ST_SECURE  = 4;
  localparam int FCR_ST_NVM_LO  = 8;
  localparam int FCR_ST_LOCK_LO = 16;

  // ==========================================================
  // array geometry: 512 pages, 16 lock regions of 32 pages
  localparam int FCR_PAGE_W   = 10; // page_number field width
  localparam int FCR_REGION_W = 4;
  localparam int FCR_REG_SH   = 5;  // page to region shift
  localparam int FCR_NVM_N    = 2;
  localparam int FCR_REGION_N = 16;
  localparam logic [15:0] FCR_LOCK_RESET = 16'h0000;

  // ==========================================================
  // command codes
  typedef enum logic [3:0] {
    FCR_OP_NOP    = 4'h0,
    FCR_OP_WRITE  = 4'h1,
    FCR_OP_LOCK   = 4'h2,
    FCR_OP_WR_LCK = 4'h3,
    FCR_OP_UNLOCK = 4'h4,
    FCR_OP_ERASE  = 4'h8,
    FCR_OP_NVM_ON = 4'hb,
    FCR_OP_NVM_OF = 4'hd,
    FCR_OP_SECURE = 4'hf
  } fcr_op_t;

  // ==========================================================
  // timing in microseconds, scaled by microsecond_cycle_count
  localparam logic [15:0] FCR_T_ERASE_US = 16'd2000;  // page erase
  localparam logic [15:0] FCR_T_PROG_US  = 16'd2000;  // page program
  localparam logic [15:0] FCR_T_BIT_US   = 16'd100;   // lock / nvm bit
  localparam logic [15:0] FCR_T_ALL_US   = 16'd10000; // erase all
  localparam logic [15:0] FCR_T_ONE_US   = 16'd1;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fcr_bus_t;

  // array operation request shown to the flash macro
  typedef struct packed {
    logic       erase;  // page erase phase
    logic       prog;   // page program phase
    logic       all;    // whole array erase
    logic [9:0] page;
  } fcr_array_t;

endpackage

// File: rtl/fcr_us_timer.sv
// module: microsecond tick divider and operation length counter
`timescale 1ns/1ps
module fcr_us_timer
  import fcr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  cycles_per_us,
  input  wire logic        start,
  input  wire logic [15:0] length_us,
  output logic             done
);

  // ==========================================================
  // state of the timer
  typedef struct packed {
    logic [7:0]  div;  // cycles inside current microsecond
    logic [15:0] left; // microseconds still to run
    logic        run;
    logic        done;
  } fcr_tmr_t;

  fcr_tmr_t st_ff;  // registered state
  fcr_tmr_t nxt_st; // next state

  // ==========================================================
  // count cycles; a zero count means one cycle per microsecond,
  // which matches a clock slower than one microsecond per cycle
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (start)
    begin
      nxt_st.run  = 1'b1;
      nxt_st.div  = 8'h00;
      nxt_st.left = (length_us == 16'h0000) ? FCR_T_ONE_US : length_us;
    end
    else if (st_ff.run)
    begin
      if ((st_ff.div + 8'h01) >= cycles_per_us)
      begin
        nxt_st.div = 8'h00; // one microsecond elapsed
        if (st_ff.left == FCR_T_ONE_US)
        begin
          nxt_st.run  = 1'b0;
          nxt_st.done = 1'b1;
        end
        else
          nxt_st.left = st_ff.left - FCR_T_ONE_US;
      end
      else
        nxt_st.div = st_ff.div + 8'h01;
    end
  end

  // register the state
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign done = st_ff.done;

endmodule

// File: tb/fcr_flash_regs_properties.sv
// checker: port level properties of the flash register block
`timescale 1ns/1ps
module fcr_flash_regs_chk
  import fcr_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                clk_en,
  input wire fcr_pkg::fcr_bus_t   bus,
  input wire logic [31:0]         rdata,
  input wire logic                irq,
  input wire fcr_pkg::fcr_array_t array_op,
  input wire logic [2:0]          read_cycles,
  input wire logic [2:0]          write_cycles
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] mode_ff; // shadow of flash_mode as software wrote it
  // ==========================================================
  // shadow register, so enables and skip bit are known here
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      mode_ff <= FCR_MODE_RESET;
    else if (clk_en && bus.wr && bus.addr == FCR_OFS_MODE)
      mode_ff <= bus.wdata & FCR_MODE_MASK;
  end
  // ==========================================================
  // erase phase must hand over to the program phase
  sequence s_erase_end;
    $fell(array_op.erase);
  endsequence
  a_mode_readback: assert property ($past(bus.rd && bus.addr == FCR_OFS_MODE)
    |-> rdata == $past(mode_ff)) else $error("mode readback wrong");
  a_command_wo: assert property ($past(bus.rd && bus.addr == FCR_OFS_COMMAND)
    |-> rdata == 32'h0) else $error("command reads not zero");
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_ws_track: assert property (read_cycles != 3'h0 |-> read_cycles ==
    {1'b0, $past(mode_ff[9:8])} + 3'h1) else $error("read cycles");
  a_ws_write: assert property (read_cycles != 3'h0 |-> write_cycles ==
    ((read_cycles == 3'h4) ? 3'h4 : read_cycles + 3'h1))
    else $error("write cycles");
  a_irq_masked: assert property (mode_ff[0] == 1'b0 && mode_ff[2] == 1'b0 &&
    mode_ff[3] == 1'b0 |-> !irq) else $error("irq while masked");
  a_erase_first: assert property ($rose(array_op.erase) |->
    !$past(mode_ff[FCR_MODE_SKIP_ER])) else $error("erase with skip");
  a_erase_then_prog: assert property (s_erase_end |-> ##[0:2] array_op.prog)
    else $error("no program after erase");
  a_page_hold: assert property ((array_op.prog || array_op.erase) &&
    $past(array_op.prog || array_op.erase) |-> $stable(array_op.page))
    else $error("page moved during operation");
  a_one_phase: assert property ($onehot0({array_op.erase, array_op.prog,
    array_op.all})) else $error("phases overlap");
endmodule

bind fcr_flash_regs fcr_flash_regs_chk u_chk (.core_clk(core_clk),
  .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .rdata(rdata), .irq(irq),
  .array_op(array_op), .read_cycles(read_cycles),
  .write_cycles(write_cycles));

// File: tb/fcr_host_model.sv
// partner: processor side master of the flash register port
`timescale 1ns/1ps
module fcr_host_model
  import fcr_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic [31:0]  rdata,
  output fcr_pkg::fcr_bus_t bus
);
  initial bus = '0;
  // ==========================================================
  // strobe one cycle, then an idle cycle so no signal is set twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge core_clk);
    bus.wr    <= 1'b0;
    @(posedge core_clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge core_clk);
    bus.rd   <= 1'b0;
    @(posedge core_clk);
    d = rdata;
  endtask
  // command word with the key byte on top
  task automatic cmd(input logic [3:0] c, input logic [9:0] p,
                     input logic [7:0] k);
    wr(FCR_OFS_COMMAND, {k, 6'h0, p, 4'h0, c});
  endtask
  // poll ready before the next command; bounded so a hang ends
  task automatic wait_rdy(output int n);
    logic [31:0] d;
    n = 2;
    d = '0;
    while (d[FCR_ST_READY] !== 1'b1 && n < 40000)
    begin
      rd(FCR_OFS_STATUS, d);
      n = n + 2;
    end
  endtask
endmodule

// File: tb/fcr_flash_regs_test.sv
// bench: random and corner tests of the flash register block
`timescale 1ns/1ps
module fcr_flash_regs_test;
  import fcr_pkg::*;
  localparam logic [31:0] US1 = 32'h0001_0000; // one cycle per microsecond
  logic        core_clk;
  logic        rst_n;
  fcr_bus_t    bus;
  logic [31:0] rdata;
  logic        irq;
  fcr_array_t  array_op;
  logic [2:0]  rd_cyc;
  logic [2:0]  wr_cyc;
  int          errors;
  int          cmp_count;
  int          n;
  logic [31:0] d;
  logic [31:0] q;                   // read back value
  logic        ce;                  // clock enable to the block
  logic [9:0]  pg;
  logic [15:0] lk;                  // expected region locks
  logic [1:0]  nv;                  // expected user nvm bits
  logic        sec, le, pe;         // expected flags
  logic [3:0]  bad [8] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc, 4'he, 4'h1};
  fcr_flash_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(ce),
    .bus(bus), .rdata(rdata), .irq(irq), .array_op(array_op),
    .read_cycles(rd_cyc), .write_cycles(wr_cyc));
  fcr_host_model u_host (.core_clk(core_clk), .rdata(rdata), .bus(bus));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ==========================================================
  // expectation and comparison helpers
  function automatic logic [31:0] st_exp();
    return {lk, 6'h0, nv, 3'h0, sec, pe, le, 1'b0, 1'b1};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    {lk, nv, sec, le, pe} = '0;
    @(posedge core_clk);
  endtask
  // status read clears the lock error, so the model follows
  task automatic st();
    u_host.rd(FCR_OFS_STATUS, d);
    check(d, st_exp());
    le = 1'b0;
  endtask
  task automatic fin(input int lo);
    u_host.wait_rdy(n);
    check(32'(n >= lo && n <= lo + 8), 32'h1);
  endtask
  task automatic run(input logic [3:0] c, input logic [9:0] p, input int lo);
    u_host.cmd(c, p, FCR_KEY_VALUE);
    fin(lo);
  endtask
  task automatic flags(input logic [2:0] e);
    check({29'h0, array_op.erase, array_op.prog, array_op.all}, 32'(e));
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    errors = 0;
    cmp_count = 0;
    void'($urandom(32'h05cc));
    reset_dut();
    st();
    u_host.rd(FCR_OFS_MODE, d);
    check(d, FCR_MODE_RESET);
    u_host.rd(8'h70 + 8'($urandom_range(0, 15)), d);
    check(d, 32'h0);
    u_host.rd(FCR_OFS_COMMAND, d);
    check(d, 32'h0);
    u_host.wr(FCR_OFS_STATUS, 32'hffff_ffff);
    st();
    for (int w = 0; w < 4; w++)
    begin
      d = ($urandom() & ~32'h300) | (32'(w) << FCR_MODE_WS_LO);
      u_host.wr(FCR_OFS_MODE, d);
      u_host.rd(FCR_OFS_MODE, q);
      check(q, d & FCR_MODE_MASK);
      check({29'h0, rd_cyc}, 32'(w + 1));
      check({29'h0, wr_cyc}, 32'((w == 3) ? 4 : w + 2));
    end
    u_host.wr(FCR_OFS_MODE, US1 | 32'h1);
    check({31'h0, irq}, 32'h1);
    u_host.wr(FCR_OFS_MODE, US1);
    check({31'h0, irq}, 32'h0);
    ce <= 1'b0;
    u_host.wr(FCR_OFS_MODE, US1 | 32'h1);
    ce <= 1'b1;
    u_host.rd(FCR_OFS_MODE, q);
    check(q, US1);
    check({31'h0, irq}, 32'h0);
    u_host.cmd(FCR_OP_NOP, 10'($urandom()), FCR_KEY_VALUE);
    st();
    for (int i = 0; i < 8; i++)
    begin
      reset_dut();
      u_host.wr(FCR_OFS_MODE, US1);
      u_host.cmd(bad[i], 10'($urandom()),
                 (i < 7) ? FCR_KEY_VALUE : 8'($urandom_range(0, 89)));
      flags(3'b000);
      pe = 1'b1;
      st();
    end
    u_host.wr(FCR_OFS_MODE, US1 | 32'h8);
    check({31'h0, irq}, 32'h1);
    u_host.wr(FCR_OFS_MODE, US1 | 32'h4);
    check({31'h0, irq}, 32'h0);
    reset_dut();
    pg = 10'($urandom_range(0, 511));
    u_host.wr(FCR_OFS_MODE, US1);
    u_host.cmd(FCR_OP_WRITE, pg, FCR_KEY_VALUE);
    check({19'h0, array_op}, {19'h0, 3'b100, pg});
    fin(4000);
    u_host.wr(FCR_OFS_MODE, US1 | 32'h80);
    u_host.cmd(FCR_OP_WRITE, pg, FCR_KEY_VALUE);
    check({19'h0, array_op}, {19'h0, 3'b010, pg});
    fin(2000);
    run(FCR_OP_LOCK, pg, 100);
    lk[pg[8:5]] = 1'b1;
    st();
    u_host.wr(FCR_OFS_MODE, US1 | 32'h84);
    u_host.cmd(FCR_OP_WRITE, {pg[9:5], 5'($urandom())}, FCR_KEY_VALUE);
    check({31'h0, irq}, 32'h1);
    flags(3'b000);
    le = 1'b1;
    st();
    st();
    check({31'h0, irq}, 32'h0);
    u_host.cmd(FCR_OP_ERASE, 10'($urandom()), FCR_KEY_VALUE);
    flags(3'b000);
    le = 1'b1;
    st();
    run(FCR_OP_UNLOCK, {pg[9:5], ~pg[4:0]}, 100);
    lk = '0;
    st();
    run(FCR_OP_WR_LCK, pg, 2100);
    lk[pg[8:5]] = 1'b1;
    st();
    run(FCR_OP_UNLOCK, pg, 100);
    lk = '0;
    u_host.cmd(FCR_OP_ERASE, 10'($urandom()), FCR_KEY_VALUE);
    flags(3'b001);
    fin(10000);
    for (int i = 0; i < 2; i++)
    begin
      run(FCR_OP_NVM_ON, 10'(i), 100);
      nv[i] = 1'b1;
      st();
      run(FCR_OP_NVM_OF, 10'(i), 100);
      nv[i] = 1'b0;
      st();
    end
    run(FCR_OP_SECURE, 10'($urandom()), 100);
    sec = 1'b1;
    st();
    u_host.wr(FCR_OFS_MODE, US1 | 32'h1);
    u_host.cmd(FCR_OP_LOCK, pg, FCR_KEY_VALUE);
    check({31'h0, irq}, 32'h0);
    fin(100);
    check({31'h0, irq}, 32'h1);
    close_out();
  end
  // watchdog: the run needs about 20000 cycles
  initial
  begin
    repeat (60000) @(posedge core_clk);
    errors++;
    close_out();
  end
endmodule
